// ==== pkg/tscb_consts.svh ====
`ifndef TSCB_CONSTS_SVH
`define TSCB_CONSTS_SVH
// ==========================================
// buffer geometry
`define TSCB_BLOCK_WORDS  10'd512
`define TSCB_BLOCK_LAST   9'h1ff
`define TSCB_WORD_BYTES   23'd4
`define TSCB_BLOCK_BYTES  23'd2048
`define TSCB_BLOCK_KB     13'd2
`define TSCB_KB_WORDS_SH  8
// ==========================================
// setting limits and reset values
`define TSCB_LEN_MIN      13'd1
`define TSCB_LEN_MAX      13'd4096
`define TSCB_LEN_RST      13'd4096
`define TSCB_RATE_MAX     5'd20
`define TSCB_RATE_RST     5'd0
`define TSCB_GET_MAX      7'd64
// ==========================================
// status word bit positions
`define TSCB_ST_REC       0
`define TSCB_ST_TRIG      1
`define TSCB_ST_WRAP      2
`endif

// ==== pkg/tscb_pkg.sv ====
package tscb_pkg;
	// ==========================================
	// control states
	typedef enum logic [2:0] {
		TSCB_IDLE  = 3'b000,
		TSCB_ARMED = 3'b001,
		TSCB_RUN   = 3'b010,
		TSCB_FILL  = 3'b011,
		TSCB_READ  = 3'b100
	} tscb_state_e;
	// ==========================================
	// start mode codes
	typedef enum logic [1:0] {
		TSCB_IMMEDIATE   = 2'b00,
		TSCB_TRIG_START  = 2'b01,
		TSCB_PER_TRIGGER = 2'b10,
		TSCB_MODE_BAD    = 2'b11
	} tscb_mode_e;
	// ==========================================
	// acquisition codes
	typedef enum logic {
		TSCB_SINGLE_FILL = 1'b0,
		TSCB_CONTINUOUS  = 1'b1
	} tscb_acq_e;
endpackage

// ==== core/tscb_mem.sv ====
`timescale 1ns/10ps
// ==========================================
// single port sample store, registered read
module tscb_mem (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        we,
	input  wire logic [19:0] addr,
	input  wire logic [31:0] wdata,
	output logic      [31:0] rdata
);
	logic [31:0] store [0:1048575];

	// array has no reset: contents are lost at power-up anyway
	always_ff @(posedge clk) begin
		if (we) begin
			store[addr] <= wdata;
		end
	end

	// read port register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= 32'h0;
		end else begin
			rdata <= store[addr];
		end
	end
endmodule

// ==== core/tscb_capture.sv ====
`timescale 1ns/10ps
`include "tscb_consts.svh"
module tscb_capture (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        capture_begin_cmd,
	input  wire logic        begin_acq,
	input  wire logic [1:0]  begin_mode,
	input  wire logic        capture_halt_cmd,
	input  wire logic        buffer_length_wr,
	input  wire logic [12:0] buffer_length_setting,
	input  wire logic        parameter_set_wr,
	input  wire logic [1:0]  parameter_set_setting,
	input  wire logic        rate_wr,
	input  wire logic [4:0]  rate_divider_exponent,
	input  wire logic [20:0] max_rate_period,
	input  wire logic [31:0] sample_x,
	input  wire logic [31:0] sample_y,
	input  wire logic [31:0] sample_r,
	input  wire logic [31:0] sample_th,
	input  wire logic        external_trigger_input,
	input  wire logic        block_readout_req,
	input  wire logic [12:0] readout_offset_kb,
	input  wire logic [6:0]  readout_len_kb,
	output logic      [2:0]  capture_state_word,
	output logic      [22:0] stored_byte_count,
	output logic      [12:0] written_kbyte_count,
	output logic             readout_valid,
	output logic      [31:0] readout_data,
	output logic             readout_range_err
);
	// ==========================================
	// trigger synchroniser
	logic [2:0] ts, next_ts;
	logic       fall;

	// ts[0] feeds only ts[1]; edge seen on the settled pair
	always_comb begin
		next_ts = {ts[1:0], external_trigger_input};
		fall    = ts[2] & ~ts[1];
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ts <= 3'h7;
		end else begin
			ts <= next_ts;
		end
	end

	// ==========================================
	// rate divider
	logic [20:0] pcnt, next_pcnt, ecnt, next_ecnt, period, mask;
	logic [4:0]  rate_exp, next_rate_exp;
	logic        base_end, tick;

	// period is read live so a time constant change bites at once
	always_comb begin
		period    = (max_rate_period == 21'h0) ? 21'h1 : max_rate_period;
		base_end  = pcnt >= period - 21'h1;
		mask      = (21'h1 << rate_exp) - 21'h1;
		tick      = base_end && ((ecnt & mask) == mask);
		next_pcnt = base_end ? 21'h0 : pcnt + 21'h1;
		next_ecnt = base_end ? ecnt + 21'h1 : ecnt;
		next_rate_exp = rate_exp;
		if (rate_wr) begin
			next_rate_exp = (rate_divider_exponent > `TSCB_RATE_MAX) ?
				`TSCB_RATE_MAX : rate_divider_exponent;
		end
		if (capture_begin_cmd) begin
			next_pcnt = 21'h0;
			next_ecnt = 21'h0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pcnt     <= 21'h0;
			ecnt     <= 21'h0;
			rate_exp <= `TSCB_RATE_RST;
		end else begin
			pcnt     <= next_pcnt;
			ecnt     <= next_ecnt;
			rate_exp <= next_rate_exp;
		end
	end

	// ==========================================
	// capture control
	tscb_pkg::tscb_state_e st, next_st;
	tscb_pkg::tscb_mode_e  mode, next_mode;
	tscb_pkg::tscb_acq_e   acq, next_acq;
	logic [1:0]  pset, next_pset, wi, next_wi, nw, rv, next_rv;
	logic [12:0] len_kb, next_len_kb, kb, next_kb, lenv, next_written;
	logic [19:0] ptr, next_ptr, raddr, next_raddr, mem_addr, next_mem_addr;
	logic [20:0] len_words, off_w;
	logic [14:0] rleft, next_rleft;
	logic [22:0] bytes, next_bytes;
	logic [31:0] samp [4];
	logic [31:0] next_samp [4];
	logic [31:0] mem_wdata, next_mem_wdata, mem_q, next_rd_data;
	logic        busy, next_busy, trig_f, next_trig_f, wrap_f, next_wrap_f;
	logic        mem_we, next_mem_we, next_rd_err, ev, last, do_halt, reset_sys;

	// one, two, two or four words per sample
	always_comb begin
		case (pset)
			2'b00:   nw = 2'd0;
			2'b11:   nw = 2'd3;
			default: nw = 2'd1;
		endcase
	end

	always_comb begin
		next_st = st;  next_mode = mode;  next_acq = acq;  next_pset = pset;
		next_len_kb = len_kb;  next_ptr = ptr;  next_busy = busy;  next_wi = wi;
		next_samp = samp;  next_bytes = bytes;  next_kb = kb;
		next_trig_f = trig_f;  next_wrap_f = wrap_f;
		next_raddr = raddr;  next_rleft = rleft;  next_mem_addr = mem_addr;
		next_mem_we = 1'b0;  next_mem_wdata = 32'h0;  next_rd_err = 1'b0;
		next_rv = {rv[0], 1'b0};
		next_rd_data = rv[1] ? mem_q : readout_data;
		len_words = {len_kb, 8'h00};
		last = ({1'b0, ptr} == len_words - 21'h1);
		lenv = 13'h0;
		off_w = {readout_offset_kb, 8'h00};
		if (off_w >= len_words) begin
			off_w = off_w - len_words;
		end
		// per-trigger ignores the divider
		ev = (mode == tscb_pkg::TSCB_PER_TRIGGER) ? fall : tick;
		// write path: sample words, then zeros once halted
		if ((st == tscb_pkg::TSCB_RUN && busy) || st == tscb_pkg::TSCB_FILL) begin
			next_mem_we    = 1'b1;
			next_mem_addr  = ptr;
			next_mem_wdata = busy ? samp[wi] : 32'h0;
			if (busy) begin
				// zero-fill words never count as data
				next_bytes = bytes + `TSCB_WORD_BYTES -
					((wrap_f && ptr[8:0] == 9'h0) ? `TSCB_BLOCK_BYTES : 23'h0);
				next_busy = (wi != nw);
				next_wi   = wi + 2'd1;
			end
			if (ptr[8:0] == `TSCB_BLOCK_LAST && !wrap_f) begin
				next_kb = kb + `TSCB_BLOCK_KB;
			end
			next_ptr = last ? 20'h0 : ptr + 20'h1;
			if (last) begin
				next_wrap_f = wrap_f | (st == tscb_pkg::TSCB_RUN);
				if (acq == tscb_pkg::TSCB_SINGLE_FILL) begin
					next_st = tscb_pkg::TSCB_IDLE;
				end
			end
			if (st == tscb_pkg::TSCB_FILL && ptr[8:0] == `TSCB_BLOCK_LAST) begin
				next_st = tscb_pkg::TSCB_IDLE;
			end
		end
		// latch a sample; events while busy are lost
		if (st == tscb_pkg::TSCB_RUN && !busy && ev) begin
			next_busy = 1'b1;
			next_wi   = 2'd0;
			case (pset)
				2'b00:   next_samp[0] = sample_x;
				2'b01:   begin next_samp[0] = sample_x; next_samp[1] = sample_y; end
				2'b10:   begin next_samp[0] = sample_r; next_samp[1] = sample_th; end
				default: next_samp = '{sample_x, sample_y, sample_r, sample_th};
			endcase
		end
		// armed single-fill start on edge
		if (st == tscb_pkg::TSCB_ARMED && fall) begin
			next_st     = tscb_pkg::TSCB_RUN;
			next_trig_f = 1'b1;
		end
		// block readout, only while stopped
		if (st == tscb_pkg::TSCB_READ) begin
			next_mem_addr = raddr;
			next_rv[0]    = 1'b1;
			next_raddr    = ({1'b0, raddr} == len_words - 21'h1) ? 20'h0 : raddr + 20'h1;
			next_rleft    = rleft - 15'h1;
			if (rleft == 15'h1) begin
				next_st = tscb_pkg::TSCB_IDLE;
			end
		end
		if (block_readout_req) begin
			if (st == tscb_pkg::TSCB_IDLE && readout_len_kb != 7'h0 &&
				readout_len_kb <= `TSCB_GET_MAX) begin
				next_st    = tscb_pkg::TSCB_READ;
				next_raddr = off_w[19:0];
				next_rleft = {readout_len_kb, 8'h00};
			end else if (st != tscb_pkg::TSCB_READ) begin
				next_rd_err = 1'b1;
			end
		end
		// halt by command or by edge in continuous trigger mode
		do_halt = capture_halt_cmd || (mode == tscb_pkg::TSCB_TRIG_START && fall &&
			acq == tscb_pkg::TSCB_CONTINUOUS);
		if (do_halt && st == tscb_pkg::TSCB_ARMED && capture_halt_cmd) begin
			next_st = tscb_pkg::TSCB_IDLE;
		end else if (do_halt && st == tscb_pkg::TSCB_RUN && next_st == tscb_pkg::TSCB_RUN) begin
			next_st = (next_ptr[8:0] == 9'h0 && !next_busy) ?
				tscb_pkg::TSCB_IDLE : tscb_pkg::TSCB_FILL;
		end
		// any of these resets the capture system
		reset_sys = buffer_length_wr || parameter_set_wr ||
			(capture_begin_cmd && begin_mode != tscb_pkg::TSCB_MODE_BAD);
		if (reset_sys) begin
			next_st = tscb_pkg::TSCB_IDLE;  next_ptr = 20'h0;  next_busy = 1'b0;
			next_bytes = 23'h0;  next_kb = 13'h0;
			next_trig_f = 1'b0;  next_wrap_f = 1'b0;
			next_rv = 2'b00;
		end
		if (buffer_length_wr) begin
			lenv = buffer_length_setting;
			if (lenv < `TSCB_LEN_MIN) lenv = `TSCB_LEN_MIN;
			if (lenv > `TSCB_LEN_MAX) lenv = `TSCB_LEN_MAX;
			next_len_kb = lenv + {12'h0, lenv[0]};
		end
		if (parameter_set_wr) begin
			next_pset = parameter_set_setting;
		end
		if (capture_begin_cmd && begin_mode != tscb_pkg::TSCB_MODE_BAD) begin
			next_mode = tscb_pkg::tscb_mode_e'(begin_mode);
			next_acq  = tscb_pkg::tscb_acq_e'(begin_acq);
			if (begin_mode == tscb_pkg::TSCB_TRIG_START && !begin_acq) begin
				next_st = tscb_pkg::TSCB_ARMED;
			end else begin
				next_st     = tscb_pkg::TSCB_RUN;
				next_trig_f = 1'b1;
			end
		end
		next_written = (next_wrap_f && next_acq == tscb_pkg::TSCB_CONTINUOUS) ?
			next_len_kb : next_kb;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= tscb_pkg::TSCB_IDLE;  mode <= tscb_pkg::TSCB_IMMEDIATE;
			acq <= tscb_pkg::TSCB_SINGLE_FILL;  pset <= 2'b00;
			len_kb <= `TSCB_LEN_RST;  ptr <= 20'h0;  busy <= 1'b0;  wi <= 2'd0;
			samp <= '{32'h0, 32'h0, 32'h0, 32'h0};  bytes <= 23'h0;  kb <= 13'h0;
			trig_f <= 1'b0;  wrap_f <= 1'b0;  raddr <= 20'h0;  rleft <= 15'h0;
			rv <= 2'b00;  mem_we <= 1'b0;  mem_addr <= 20'h0;  mem_wdata <= 32'h0;
			capture_state_word <= 3'h0;  stored_byte_count <= 23'h0;
			written_kbyte_count <= 13'h0;  readout_valid <= 1'b0;
			readout_data <= 32'h0;  readout_range_err <= 1'b0;
		end else begin
			st <= next_st;  mode <= next_mode;  acq <= next_acq;  pset <= next_pset;
			len_kb <= next_len_kb;  ptr <= next_ptr;  busy <= next_busy;  wi <= next_wi;
			samp <= next_samp;  bytes <= next_bytes;  kb <= next_kb;
			trig_f <= next_trig_f;  wrap_f <= next_wrap_f;  raddr <= next_raddr;
			rleft <= next_rleft;  rv <= next_rv;  mem_we <= next_mem_we;
			mem_addr <= next_mem_addr;  mem_wdata <= next_mem_wdata;
			capture_state_word <= {next_wrap_f, next_trig_f,
				next_st == tscb_pkg::TSCB_RUN || next_st == tscb_pkg::TSCB_FILL};
			stored_byte_count <= next_bytes;
			written_kbyte_count <= next_written;
			readout_valid <= rv[1];
			readout_data <= next_rd_data;
			readout_range_err <= next_rd_err;
		end
	end

	// ==========================================
	// sample store
	tscb_mem u_mem (
		.clk   (clk),
		.rst   (rst),
		.we    (mem_we),
		.addr  (mem_addr),
		.wdata (mem_wdata),
		.rdata (mem_q)
	);

	// ==========================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	armed_zero_a: assert property (st == tscb_pkg::TSCB_ARMED |-> capture_state_word == 3'h0)
		else $error("status not zero while armed");
	edge_start_a: assert property (st == tscb_pkg::TSCB_ARMED && fall && !reset_sys &&
		!capture_halt_cmd |=> st == tscb_pkg::TSCB_RUN && capture_state_word == 3'h3)
		else $error("edge did not start capture");
	halt_abort_a: assert property (st == tscb_pkg::TSCB_ARMED && capture_halt_cmd &&
		!reset_sys |=> st == tscb_pkg::TSCB_IDLE)
		else $error("halt did not abort armed wait");
	halt_idle_a: assert property (st == tscb_pkg::TSCB_IDLE && capture_halt_cmd &&
		!reset_sys && !block_readout_req |=> st == tscb_pkg::TSCB_IDLE)
		else $error("halt changed idle capture");
	sticky_bits_a: assert property (capture_state_word[2:1] == 2'b11 && !reset_sys |=>
		capture_state_word[2:1] == 2'b11)
		else $error("sticky status bit lost");
	zero_fill_a: assert property (st == tscb_pkg::TSCB_FILL && !busy |=>
		mem_we && mem_wdata == 32'h0)
		else $error("fill word not zero");
	fill_ends_a: assert property (st == tscb_pkg::TSCB_FILL |->
		capture_state_word[0] ##[1:600] st != tscb_pkg::TSCB_FILL)
		else $error("zero fill did not end");
	len_even_a: assert property (len_kb[0] == 1'b0 && len_kb >= 13'd2 &&
		len_kb <= `TSCB_LEN_MAX)
		else $error("buffer length out of range");
	range_err_a: assert property (block_readout_req && capture_state_word[0] &&
		st != tscb_pkg::TSCB_READ |=> readout_range_err)
		else $error("no range error while running");
	per_trig_a: assert property (st == tscb_pkg::TSCB_RUN && !busy && fall &&
		mode == tscb_pkg::TSCB_PER_TRIGGER && !reset_sys |=> busy)
		else $error("trigger edge did not take a sample");
	byte_drop_a: assert property (busy && wrap_f && ptr[8:0] == 9'h0 &&
		st == tscb_pkg::TSCB_RUN && !reset_sys |=> bytes == $past(bytes) - 23'd2044)
		else $error("byte count did not drop on overwrite");

	run_cov: cover property (st == tscb_pkg::TSCB_RUN ##1 st == tscb_pkg::TSCB_FILL);
	wrap_cov: cover property ($rose(wrap_f) && acq == tscb_pkg::TSCB_CONTINUOUS);
	read_cov: cover property (readout_valid ##1 !readout_valid);
endmodule

// ==== tb/tscb_trig_src.sv ====
`timescale 1ns/10ps
// ==========================================
// trigger source, line pulled up when idle
module tscb_trig_src (
	input  wire logic clk,
	input  wire logic fire,
	output logic      trig
);
	logic [2:0] low_cnt = 3'h0;
	logic [2:0] next_low_cnt;
	// edges only on request; bench spaces them past the max rate
	always_comb begin
		next_low_cnt = low_cnt;
		if (fire && low_cnt == 3'h0) begin
			next_low_cnt = 3'h3;
		end else if (low_cnt != 3'h0) begin
			next_low_cnt = low_cnt - 3'h1;
		end
	end
	always_ff @(posedge clk) begin
		low_cnt <= next_low_cnt;
	end
	// three clocks low so the synchroniser cannot miss it
	assign trig = (low_cnt == 3'h0);
endmodule

// ==== tb/triggered_sample_capture_buffer_bench.sv ====
`timescale 1ns/10ps
// ==========================================
// bench for the capture controller
module triggered_sample_capture_buffer_bench;
	logic        clk, rst, go, acq, hlt, len_wr, set_wr, rt_wr, fire, rd_req, trig;
	logic [1:0]  mode, pset;
	logic [4:0]  rexp;
	logic [12:0] blen, roff, kb;
	logic [6:0]  rlen;
	logic [20:0] per;
	logic [31:0] smp [4];
	logic [2:0]  st;
	logic [22:0] bytes, b0;
	logic        rv, rerr;
	logic [31:0] rdata;
	logic [31:0] exp_q [$];
	int          num_errors, n_tests, errs_seen;

	tscb_capture u_dut (.clk(clk), .rst(rst), .capture_begin_cmd(go), .begin_acq(acq),
		.begin_mode(mode), .capture_halt_cmd(hlt), .buffer_length_wr(len_wr),
		.buffer_length_setting(blen), .parameter_set_wr(set_wr),
		.parameter_set_setting(pset), .rate_wr(rt_wr), .rate_divider_exponent(rexp),
		.max_rate_period(per), .sample_x(smp[0]), .sample_y(smp[1]), .sample_r(smp[2]),
		.sample_th(smp[3]), .external_trigger_input(trig), .block_readout_req(rd_req),
		.readout_offset_kb(roff), .readout_len_kb(rlen), .capture_state_word(st),
		.stored_byte_count(bytes), .written_kbyte_count(kb), .readout_valid(rv),
		.readout_data(rdata), .readout_range_err(rerr));
	tscb_trig_src u_trig (.clk(clk), .fire(fire), .trig(trig));

	// ==========================================
	// shared tasks
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		n_tests++;
		if (seen !== want) begin
			num_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, want);
		end
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
	endtask
	task automatic start(input logic a, input logic [1:0] m);
		acq = a;
		mode = m;
		pulse(go);
	endtask
	// parameter write also resets the capture
	task automatic set_cfg(input logic [1:0] s, input logic [20:0] p, input logic [4:0] e);
		pset = s;
		per = p;
		rexp = e;
		pulse(set_wr);
		pulse(rt_wr);
	endtask
	task automatic readout(input logic [12:0] o, input logic [6:0] l);
		roff = o;
		rlen = l;
		pulse(rd_req);
	endtask
	// bounded wait, a hang shows up in the next compare
	task automatic wait_idle;
		int k;
		k = 0;
		while (st[0] !== 1'b0 && k < 5000) begin
			cyc(1);
			k++;
		end
	endtask
	task automatic endt(input string s);
		$display("test %s done", s);
	endtask
	task automatic report_and_stop;
		$display("comparisons=%0d mismatches=%0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ==========================================
	// clock, monitor and watchdog
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// each readout word takes the oldest note off the queue
	always @(posedge clk) begin
		if (rv === 1'b1) begin
			if (exp_q.size() == 0)
				chk(32'h1, 32'h0);
			else
				chk(rdata, exp_q.pop_front());
		end
		if (rerr === 1'b1)
			errs_seen++;
	end
	// whole run is under 15000 cycles
	initial begin
		#200000;
		num_errors++;
		report_and_stop;
	end

	// ==========================================
	// scenarios
	initial begin
		{rst, go, acq, hlt, len_wr, set_wr, rt_wr, fire, rd_req} = 9'h100;
		{mode, pset, rexp, roff, rlen} = '0;
		blen = 13'h1;
		per = 21'h1;
		smp[0] = $urandom(97311);
		for (int i = 1; i < 4; i++)
			smp[i] = $urandom();
		cyc(6);
		rst = 1'b0;
		chk(st, 3'h0);
		chk(bytes, 23'h0);
		endt("reset");
		// odd length rounds up to one block, four values each sample
		pulse(len_wr);
		set_cfg(2'h3, 21'h1, 5'h0);
		start(1'b0, 2'h0);
		cyc(1);
		chk(st, 3'h3);
		wait_idle;
		chk(st, 3'h6);
		chk(bytes, 23'h800);
		chk(kb, 13'h2);
		pulse(hlt);
		start(1'b0, 2'h3);
		cyc(2);
		chk(st, 3'h6);
		for (int i = 0; i < 512; i++)
			exp_q.push_back(smp[i % 4]);
		readout(13'h1, 7'h2);
		cyc(520);
		chk(exp_q.size(), 32'h0);
		readout(13'h0, 7'h0);
		cyc(4);
		chk(errs_seen, 32'h1);
		endt("immediate");
		// trigger start, then halt mid-block
		set_cfg(2'h1, 21'h4, 5'h0);
		cyc(1);
		chk(st, 3'h0);
		start(1'b0, 2'h1);
		cyc(3);
		chk(st, 3'h0);
		pulse(fire);
		cyc(10);
		chk(st, 3'h3);
		readout(13'h0, 7'h2);
		cyc(3);
		chk(errs_seen, 32'h2);
		cyc(40);
		pulse(hlt);
		cyc(1);
		chk(st[0], 1'b1);
		wait_idle;
		chk(st, 3'h2);
		chk(kb, 13'h2);
		chk(bytes[2:0], 3'h0);
		chk(bytes != 23'h0 && bytes < 23'h800, 1'b1);
		endt("trigger start");
		// halt while armed drops later edges
		start(1'b0, 2'h1);
		cyc(2);
		pulse(hlt);
		cyc(2);
		pulse(fire);
		cyc(12);
		chk(st, 3'h0);
		endt("armed halt");
		// one sample per edge, slowest divider must not matter
		set_cfg(2'h0, 21'h4, 5'h14);
		start(1'b0, 2'h2);
		for (int k = 1; k <= 5; k++) begin
			pulse(fire);
			cyc(19);
			chk(bytes, 23'(4 * k));
		end
		pulse(hlt);
		wait_idle;
		chk(bytes, 23'h14);
		chk(kb, 13'h2);
		endt("per trigger");
		// continuous capture wraps, trigger ends it
		set_cfg(2'h0, 21'h1, 5'h0);
		start(1'b1, 2'h1);
		cyc(1200);
		chk(st, 3'h7);
		pulse(fire);
		cyc(12);
		wait_idle;
		chk(st, 3'h6);
		chk(kb, 13'h2);
		endt("trigger stop");
		// divider by four, then the max rate doubles mid-run
		set_cfg(2'h0, 21'h2, 5'h2);
		start(1'b1, 2'h0);
		cyc(800);
		b0 = bytes;
		chk(b0 >= 23'd392 && b0 <= 23'd408, 1'b1);
		per = 21'h1;
		cyc(800);
		chk(bytes - b0 >= 23'd792 && bytes - b0 <= 23'd808, 1'b1);
		pulse(hlt);
		wait_idle;
		chk(st, 3'h2);
		endt("rate");
		report_and_stop;
	end
endmodule
